// file: hw/gsm_ctrl.sv
`timescale 1ns/1ps
// Notes on behaviour
// - off mode blocks every start request
// - off while running stops at once, no stop delay
// - manual run starts, runs until off
// - manual run ignores remote start
// - auto starts only on remote start
// - auto: preheat then start delay, skip unprogrammed
// - off press in auto stops immediately
// - remote start removed: normal stop with delay
// - emergency stop shuts down, no stop delay
// - estop lights shutdown, code of latest input
// - estop clears after release then reset
// - sleep after five idle minutes off/auto
// - sleep-disable jumper forbids sleep
// - no sleep: unacked shutdown, manual, wake
// - listed wake inputs wake from sleep
// - five minutes without keys; key wakes
// - harness manual wakes; auto if configured
// - warning fault only indicates
// - shutdown fault drops load and stops in the same cycle
// - lamp steady running, flashes last shutdown
// - history holds five, newest active tagged
// - screen edits apply only on save
module gsm_ctrl #(
  parameter longint unsigned SLEEP_CYC = gsm_pkg::SLEEP_IDLE_CYC,
  parameter int unsigned FLASH_CYC = gsm_pkg::FLASH_HALF_CYC,
  parameter int unsigned DLY_W     = 24
) (
  // clock and reset
  input  wire logic                  clk,
  input  wire logic                  srst,
  input  wire logic                  ce,
  // operator panel, one-cycle pulses
  input  wire logic                  key_auto,
  input  wire logic                  key_manual,
  input  wire logic                  key_off,
  input  wire logic                  key_any,
  // harness mode switch, pin levels
  input  wire logic                  harness_fitted,
  input  wire logic                  harness_manual,
  input  wire logic                  harness_auto,
  // start and stop pins
  input  wire logic                  remote_start,
  input  wire logic                  estop_local_open,
  input  wire logic                  estop_remote_open,
  input  wire logic                  cfg_in3,
  input  wire logic                  cfg_in4,
  input  wire logic                  sys_wake_in,
  input  wire logic                  service_connector_jumper,
  // faults from monitoring logic
  input  wire logic                  warn_fault,
  input  wire logic                  sd_fault,
  input  wire logic [15:0]           sd_fault_code,
  // configuration
  input  wire logic [DLY_W-1:0]      preheat_cyc,
  input  wire logic [DLY_W-1:0]      start_dly_cyc,
  input  wire logic [DLY_W-1:0]      stop_dly_cyc,
  input  wire logic                  wake_in_auto,
  // screen adjust menu
  input  wire gsm_pkg::gsm_screen_s  screen_edit,
  input  wire logic                  screen_save,
  input  wire logic                  screen_leave,
  // status
  output gsm_pkg::gsm_mode_e         mode,
  output logic                       run_cmd,
  output logic                       load_on,
  output logic                       shutdown_lamp,
  output logic                       warning_lamp,
  output logic                       status_lamp,
  output logic                       sleep_state,
  output logic                       sys_wake_out,
  output logic                       sys_wake_oe,
  output logic [15:0]                active_code,
  output gsm_pkg::gsm_screen_s       screen_applied,
  output gsm_pkg::gsm_hist_s [gsm_pkg::HIST_DEPTH-1:0] history
);

  localparam int unsigned SYNC_N = 10;
  localparam int unsigned IDLE_W = $clog2(SLEEP_CYC + 1);

  typedef struct packed {
    logic [SYNC_N-1:0]   sync1;
    logic [SYNC_N-1:0]   sync2;
    gsm_pkg::gsm_mode_e  mode;
    gsm_pkg::gsm_run_e   run;
    logic [DLY_W-1:0]    dly;
    logic [IDLE_W-1:0]   idle;
    logic                sleep;
    logic                sd_latched;
    logic                sd_acked;
    logic                estop_latched;
    logic [15:0]         code;
    logic                prev_estop_l;
    logic                prev_estop_r;
    logic                prev_sd;
    logic                prev_harn_m;
    logic                prev_harn_a;
    logic                load;
    logic                warn;
    logic                lamp_flash_en;
    logic                run_on;
    logic                sd_lamp;
    logic                wake_oe;
    gsm_pkg::gsm_screen_s screen;
    gsm_pkg::gsm_hist_s [gsm_pkg::HIST_DEPTH-1:0] hist;
  } gsm_ctrl_s;

  gsm_ctrl_s st_r;
  gsm_ctrl_s st_nxt;
  logic      flash_lamp;
  logic      lamp_r;

  // pin order inside the synchroniser
  logic [SYNC_N-1:0] pins;
  assign pins = {harness_fitted, harness_manual, harness_auto, remote_start, estop_local_open,
                 estop_remote_open, cfg_in3, cfg_in4, sys_wake_in, service_connector_jumper};

  function automatic gsm_pkg::gsm_hist_s [gsm_pkg::HIST_DEPTH-1:0] hist_push(
    input gsm_pkg::gsm_hist_s [gsm_pkg::HIST_DEPTH-1:0] h,
    input logic [15:0] c
  );
    gsm_pkg::gsm_hist_s [gsm_pkg::HIST_DEPTH-1:0] r;
    r = h;
    for (int i = gsm_pkg::HIST_DEPTH - 1; i > 0; i--)
    begin
      r[i]        = h[i-1];
      r[i].active = 1'b0;
    end
    r[0] = '{valid: 1'b1, active: 1'b1, code: c};
    return r;
  endfunction : hist_push

  always_comb
  begin
    logic h_fit, h_man, h_auto, rs, el, er, c3, c4, sw, jmp;
    logic any_wake, go_off, go_man, go_auto, mode_chg, sd_new, estop_any, fault_reset;
    {h_fit, h_man, h_auto, rs, el, er, c3, c4, sw, jmp} = st_r.sync2;
    st_nxt = st_r;
    st_nxt.sync1 = pins;
    st_nxt.sync2 = st_r.sync1;
    go_off  = key_off || (h_fit && !h_man && !h_auto && (st_r.prev_harn_m || st_r.prev_harn_a));
    go_man  = key_manual || (h_fit && h_man && !st_r.prev_harn_m);
    go_auto = key_auto || (h_fit && h_auto && !st_r.prev_harn_a);
    st_nxt.prev_harn_m = h_man;
    st_nxt.prev_harn_a = h_auto;
    estop_any   = el || er;
    fault_reset = key_off;
    // latest-activated emergency stop selects the code
    st_nxt.prev_estop_l = el;
    st_nxt.prev_estop_r = er;
    if (el && !st_r.prev_estop_l)
    begin
      st_nxt.estop_latched = 1'b1;
      st_nxt.code          = gsm_pkg::CODE_ESTOP_LOCAL;
      st_nxt.hist          = hist_push(st_r.hist, gsm_pkg::CODE_ESTOP_LOCAL);
    end
    if (er && !st_r.prev_estop_r)
    begin
      st_nxt.estop_latched = 1'b1;
      st_nxt.code          = gsm_pkg::CODE_ESTOP_REMOTE;
      st_nxt.hist          = hist_push(st_r.hist, gsm_pkg::CODE_ESTOP_REMOTE);
    end
    sd_new = sd_fault && !st_r.prev_sd;
    st_nxt.prev_sd = sd_fault;
    if (sd_new)
    begin
      st_nxt.sd_latched = 1'b1;
      st_nxt.sd_acked   = 1'b0;
      st_nxt.code       = sd_fault_code;
      st_nxt.hist       = hist_push(st_r.hist, sd_fault_code);
    end
    // reset clears only once the cause is gone; a new event wins
    if (fault_reset && !estop_any && !(el && !st_r.prev_estop_l) && !(er && !st_r.prev_estop_r))
      st_nxt.estop_latched = 1'b0;
    if (fault_reset && !sd_new)
    begin
      st_nxt.sd_acked = 1'b1;
      if (!sd_fault)
        st_nxt.sd_latched = 1'b0;
    end
    if (fault_reset && !st_nxt.estop_latched && !st_nxt.sd_latched)
      for (int i = 0; i < gsm_pkg::HIST_DEPTH; i++)
        st_nxt.hist[i].active = 1'b0;
    st_nxt.warn = warn_fault;
    // mode selection
    mode_chg = 1'b0;
    if (go_off)
    begin
      st_nxt.mode = gsm_pkg::GSM_MODE_OFF;
      mode_chg    = st_r.mode != gsm_pkg::GSM_MODE_OFF;
    end
    else if (go_man)
    begin
      st_nxt.mode = gsm_pkg::GSM_MODE_MANUAL;
      mode_chg    = st_r.mode != gsm_pkg::GSM_MODE_MANUAL;
    end
    else if (go_auto)
    begin
      st_nxt.mode = gsm_pkg::GSM_MODE_AUTO;
      mode_chg    = st_r.mode != gsm_pkg::GSM_MODE_AUTO;
    end
    // run sequencer
    if (st_r.dly != '0)
      st_nxt.dly = st_r.dly - 1'b1;
    if (st_r.estop_latched || st_nxt.estop_latched || st_r.sd_latched || st_nxt.sd_latched)
    begin
      st_nxt.run  = gsm_pkg::GSM_ST_STOPPED;
      st_nxt.load = 1'b0;
      st_nxt.dly  = '0;
    end
    else if (st_nxt.mode == gsm_pkg::GSM_MODE_OFF)
    begin
      st_nxt.run  = gsm_pkg::GSM_ST_STOPPED;
      st_nxt.load = 1'b0;
      st_nxt.dly  = '0;
    end
    else if (st_nxt.mode == gsm_pkg::GSM_MODE_MANUAL)
    begin
      st_nxt.run  = gsm_pkg::GSM_ST_RUNNING;
      st_nxt.load = 1'b1;
    end
    else
    begin
      unique case (st_r.run)
        gsm_pkg::GSM_ST_STOPPED:
          if (rs)
          begin
            st_nxt.run = gsm_pkg::GSM_ST_PREHEAT;
            st_nxt.dly = preheat_cyc;
          end
        gsm_pkg::GSM_ST_PREHEAT:
          if (!rs)
            st_nxt.run = gsm_pkg::GSM_ST_STOPPED;
          else if (st_r.dly == '0)
          begin
            st_nxt.run = gsm_pkg::GSM_ST_START_DLY;
            st_nxt.dly = start_dly_cyc;
          end
        gsm_pkg::GSM_ST_START_DLY:
          if (!rs)
            st_nxt.run = gsm_pkg::GSM_ST_STOPPED;
          else if (st_r.dly == '0)
          begin
            st_nxt.run  = gsm_pkg::GSM_ST_RUNNING;
            st_nxt.load = 1'b1;
          end
        gsm_pkg::GSM_ST_RUNNING:
          if (!rs)
          begin
            st_nxt.run  = gsm_pkg::GSM_ST_STOP_DLY;
            st_nxt.dly  = stop_dly_cyc;
            st_nxt.load = 1'b0;
          end
        gsm_pkg::GSM_ST_STOP_DLY:
          if (rs)
          begin
            st_nxt.run  = gsm_pkg::GSM_ST_RUNNING;
            st_nxt.load = 1'b1;
          end
          else if (st_r.dly == '0)
            st_nxt.run = gsm_pkg::GSM_ST_STOPPED;
      endcase
    end
    // sleep control
    any_wake = rs || c3 || c4 || el || er || sw || key_any || go_man
               || (go_auto && wake_in_auto)
               || (st_nxt.mode == gsm_pkg::GSM_MODE_AUTO && wake_in_auto);
    if (any_wake || mode_chg)
      st_nxt.idle = '0;
    else if (st_r.idle < SLEEP_CYC)
      st_nxt.idle = st_r.idle + 1'b1;
    if (any_wake)
      st_nxt.sleep = 1'b0;
    else if (st_r.idle >= SLEEP_CYC - 1 && !jmp
             && st_nxt.mode != gsm_pkg::GSM_MODE_MANUAL
             && !((st_r.sd_latched && !st_r.sd_acked) || st_r.estop_latched)
             && st_nxt.run == gsm_pkg::GSM_ST_STOPPED)
      st_nxt.sleep = 1'b1;
    if (jmp)
      st_nxt.sleep = 1'b0;
    // screen settings apply on save only
    if (screen_save)
      st_nxt.screen = screen_edit;
    st_nxt.lamp_flash_en = (st_nxt.run != gsm_pkg::GSM_ST_RUNNING) && (st_nxt.estop_latched || st_nxt.sd_latched);
    // registered copies so every output except the constant sys_wake_out leaves a flip-flop
    st_nxt.run_on  = st_nxt.run == gsm_pkg::GSM_ST_RUNNING || st_nxt.run == gsm_pkg::GSM_ST_STOP_DLY;
    st_nxt.sd_lamp = st_nxt.estop_latched || st_nxt.sd_latched;
    st_nxt.wake_oe = !st_nxt.sleep;
  end

  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      st_r        <= '0;
      st_r.mode   <= gsm_pkg::GSM_MODE_OFF;
      st_r.run    <= gsm_pkg::GSM_ST_STOPPED;
      st_r.wake_oe <= 1'b1;
      st_r.screen <= '{contrast: gsm_pkg::CONTRAST_RST, brightness: gsm_pkg::BRIGHTNESS_RST,
                       imperial_units: gsm_pkg::IMPERIAL_RST};
      lamp_r      <= 1'b0;
    end
    else if (ce)
    begin
      st_r   <= st_nxt;
      lamp_r <= (st_r.run == gsm_pkg::GSM_ST_RUNNING) ? 1'b1 : flash_lamp;
    end
  end

  gsm_flash #(
    .HALF_CYC (FLASH_CYC)
  ) u_flash (
    .clk    (clk),
    .srst   (srst),
    .ce     (ce),
    .enable (st_r.lamp_flash_en),
    .code   (st_r.code),
    .lamp   (flash_lamp)
  );

  assign mode           = st_r.mode;
  assign run_cmd        = st_r.run_on;
  assign load_on        = st_r.load;
  assign shutdown_lamp  = st_r.sd_lamp;
  assign warning_lamp   = st_r.warn;
  assign status_lamp    = lamp_r;
  assign sleep_state    = st_r.sleep;
  assign sys_wake_out   = 1'b0;
  assign sys_wake_oe    = st_r.wake_oe;
  assign active_code    = st_r.code;
  assign screen_applied = st_r.screen;
  assign history        = st_r.hist;

endmodule : gsm_ctrl

// file: hw/gsm_flash.sv
`timescale 1ns/1ps
// flashes a decimal fault code digit by digit on the status lamp
module gsm_flash #(
  parameter int unsigned HALF_CYC = gsm_pkg::FLASH_HALF_CYC
) (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        srst,
  input  wire logic        ce,
  // code
  input  wire logic        enable,
  input  wire logic [15:0] code,
  // lamp
  output logic             lamp
);

  typedef struct packed {
    logic [31:0] tick;
    logic [1:0]  digit;
    logic [3:0]  pulses;
    logic        phase;
    logic        gap;
    logic        lamp;
  } gsm_flash_s;

  gsm_flash_s st_r;
  gsm_flash_s st_nxt;

  function automatic logic [3:0] dec_digit(input logic [15:0] v, input logic [1:0] idx);
    logic [15:0] q;
    q = v;
    for (int i = 0; i < 3 - int'(idx); i++)
      q = q / 16'd10;
    return 4'(q % 16'd10);
  endfunction : dec_digit

  always_comb
  begin
    logic [3:0] target;
    target = 4'h0;
    st_nxt = st_r;
    target = dec_digit(code, st_r.digit);
    if (!enable)
    begin
      st_nxt = '0;
    end
    else if (st_r.tick >= 32'(HALF_CYC - 1))
    begin
      st_nxt.tick = '0;
      if (st_r.gap)
      begin
        st_nxt.pulses = st_r.pulses + 4'h1;
        if (st_r.pulses + 4'h1 >= 4'(gsm_pkg::FLASH_GAP_PULSES))
        begin
          st_nxt.gap    = 1'b0;
          st_nxt.pulses = '0;
        end
        st_nxt.lamp = 1'b0;
      end
      else if (!st_r.phase && st_r.pulses < target)
      begin
        st_nxt.phase = 1'b1;
        st_nxt.lamp  = 1'b1;
      end
      else if (st_r.phase)
      begin
        st_nxt.phase  = 1'b0;
        st_nxt.lamp   = 1'b0;
        st_nxt.pulses = st_r.pulses + 4'h1;
      end
      else
      begin
        st_nxt.digit  = st_r.digit + 2'h1;
        st_nxt.pulses = '0;
        st_nxt.gap    = 1'b1;
      end
    end
    else
    begin
      st_nxt.tick = st_r.tick + 32'h1;
    end
  end

  always_ff @(posedge clk)
  begin
    if (srst)
      st_r <= '0;
    else if (ce)
      st_r <= st_nxt;
  end

  assign lamp = st_r.lamp;

endmodule : gsm_flash

// file: hw/gsm_pkg.sv
package gsm_pkg;

  // timing
  localparam int unsigned CLK_HZ        = 40_000_000;
  localparam int unsigned SLEEP_IDLE_S  = 300;
  // five idle minutes of cycles need more than 32 bits
  localparam longint unsigned SLEEP_IDLE_CYC = 64'(CLK_HZ) * SLEEP_IDLE_S;
  localparam int unsigned FLASH_HALF_MS = 500;
  localparam int unsigned FLASH_HALF_CYC = (CLK_HZ / 1000) * FLASH_HALF_MS;
  localparam int unsigned FLASH_GAP_PULSES = 4;

  // fault codes
  localparam logic [15:0] CODE_ESTOP_LOCAL  = 16'h0599;
  localparam logic [15:0] CODE_ESTOP_REMOTE = 16'h059A;
  localparam logic [15:0] CODE_NONE         = 16'h0000;

  // history depth
  localparam int unsigned HIST_DEPTH = 5;

  // reset values of screen settings
  localparam logic [3:0] CONTRAST_RST   = 4'h8;
  localparam logic [3:0] BRIGHTNESS_RST = 4'h8;
  localparam logic       IMPERIAL_RST   = 1'b1;

  typedef enum logic [1:0] {
    GSM_MODE_OFF,
    GSM_MODE_MANUAL,
    GSM_MODE_AUTO
  } gsm_mode_e;

  typedef enum logic [2:0] {
    GSM_ST_STOPPED,
    GSM_ST_PREHEAT,
    GSM_ST_START_DLY,
    GSM_ST_RUNNING,
    GSM_ST_STOP_DLY
  } gsm_run_e;

  typedef struct packed {
    logic [3:0] contrast;
    logic [3:0] brightness;
    logic       imperial_units;
  } gsm_screen_s;

  typedef struct packed {
    logic        valid;
    logic        active;
    logic [15:0] code;
  } gsm_hist_s;

  typedef struct packed {
    logic remote_start;
    logic manual_start;
    logic cfg_in3;
    logic cfg_in4;
    logic estop_local_open;
    logic estop_remote_open;
    logic sys_wake;
    logic key_press;
  } gsm_wake_s;

endpackage : gsm_pkg

// file: tb/gsm_ctrl_checker.sv
`timescale 1ns/1ps
module gsm_ctrl_checker (
  // clock and reset
  input wire logic                 clk,
  input wire logic                 srst,
  // watched inputs
  input wire logic                 key_manual,
  input wire logic                 key_off,
  input wire logic                 estop_local_open,
  input wire logic                 estop_remote_open,
  input wire logic                 service_connector_jumper,
  input wire logic                 warn_fault,
  input wire logic                 sd_fault,
  input wire logic                 screen_save,
  // watched outputs
  input wire gsm_pkg::gsm_mode_e   mode,
  input wire logic                 run_cmd,
  input wire logic                 load_on,
  input wire logic                 shutdown_lamp,
  input wire logic                 status_lamp,
  input wire logic                 sleep_state,
  input wire logic [15:0]          active_code,
  input wire gsm_pkg::gsm_screen_s screen_applied
);
  default clocking @(posedge clk); endclocking
  default disable iff (srst);

  property p_off_blocks;
    mode == gsm_pkg::GSM_MODE_OFF && !run_cmd ##1 mode == gsm_pkg::GSM_MODE_OFF |-> !run_cmd;
  endproperty
  a_off_blocks: assert property (p_off_blocks) else $error("engine started in off mode");
  property p_manual_key;
    key_manual && !key_off |=> mode == gsm_pkg::GSM_MODE_MANUAL;
  endproperty
  a_manual_key: assert property (p_manual_key) else $error("manual key did not select manual");
  property p_estop_stop;
    $rose(estop_local_open) |-> ##[1:4] (shutdown_lamp && !run_cmd && !load_on);
  endproperty
  a_estop_stop: assert property (p_estop_stop) else $error("local stop did not shut down");
  property p_estop_code;
    $rose(estop_remote_open) |-> ##[1:4] active_code == gsm_pkg::CODE_ESTOP_REMOTE;
  endproperty
  a_estop_code: assert property (p_estop_code) else $error("remote stop code missing");
  property p_estop_hold;
    (estop_local_open && shutdown_lamp) [*4] |=> shutdown_lamp;
  endproperty
  a_estop_hold: assert property (p_estop_hold) else $error("shutdown cleared with stop open");
  property p_jumper;
    service_connector_jumper [*4] |-> !sleep_state;
  endproperty
  a_jumper: assert property (p_jumper) else $error("sleep with jumper fitted");
  property p_manual_awake;
    mode == gsm_pkg::GSM_MODE_MANUAL && $past(mode) == gsm_pkg::GSM_MODE_MANUAL |-> !sleep_state;
  endproperty
  a_manual_awake: assert property (p_manual_awake) else $error("sleep in manual mode");
  property p_warn_only;
    $rose(warn_fault) && load_on && !sd_fault |=> load_on;
  endproperty
  a_warn_only: assert property (p_warn_only) else $error("warning changed run state");
  property p_sd_stop;
    $rose(sd_fault) |-> ##[1:3] !load_on ##[0:4] !run_cmd;
  endproperty
  a_sd_stop: assert property (p_sd_stop) else $error("shutdown fault kept engine on");
  property p_lamp_run;
    load_on [*3] |-> status_lamp;
  endproperty
  a_lamp_run: assert property (p_lamp_run) else $error("status lamp not steady while running");
  property p_screen_hold;
    !screen_save [*3] |=> $stable(screen_applied);
  endproperty
  a_screen_hold: assert property (p_screen_hold) else $error("screen changed without save");
endmodule : gsm_ctrl_checker

bind gsm_ctrl gsm_ctrl_checker u_chk (.clk, .srst, .key_manual, .key_off, .estop_local_open, .estop_remote_open,
  .service_connector_jumper, .warn_fault, .sd_fault, .screen_save, .mode, .run_cmd, .load_on, .shutdown_lamp,
  .status_lamp, .sleep_state, .active_code, .screen_applied);

// file: tb/gsm_panel.sv
`timescale 1ns/1ps
// operator panel, harness switch and start/stop wiring
module gsm_panel (
  // clock
  input wire logic clk,
  // panel keys, one-cycle pulses
  output logic     key_auto,
  output logic     key_manual,
  output logic     key_off,
  output logic     key_any,
  // harness switch and pins
  output logic     harness_fitted,
  output logic     harness_manual,
  output logic     harness_auto,
  output logic     remote_start,
  output logic     estop_local_open,
  output logic     estop_remote_open
);
  initial
  begin
    {key_off, key_manual, key_auto, key_any} = 4'h0;
    {harness_fitted, harness_manual, harness_auto, remote_start, estop_local_open, estop_remote_open} = 6'h00;
  end

  // k = {off, manual, auto}; every press also raises key_any
  task automatic press(input logic [2:0] k);
    @(posedge clk);
    {key_off, key_manual, key_auto, key_any} <= {k, 1'b1};
    @(posedge clk);
    {key_off, key_manual, key_auto, key_any} <= 4'h0;
  endtask : press

  // p = {fitted, manual, auto, remote start, local open, remote open}
  task automatic pins(input logic [5:0] p);
    @(posedge clk);
    {harness_fitted, harness_manual, harness_auto, remote_start, estop_local_open, estop_remote_open} <= p;
  endtask : pins
endmodule : gsm_panel

// file: tb/tb.sv
`timescale 1ns/1ps
module tb;
  localparam int unsigned SLP = 50;
  localparam int unsigned PH  = 6;
  localparam int unsigned SD  = 4;
  logic                 clk = 1'b0;
  logic                 srst = 1'b1;
  logic                 ce = 1'b1;
  logic                 key_auto, key_manual, key_off, key_any, remote_start, estop_local_open, estop_remote_open;
  logic                 harness_fitted, harness_manual, harness_auto;
  logic [2:0]           wk = 3'h0;
  logic                 service_connector_jumper = 1'b0;
  logic                 warn_fault = 1'b0;
  logic                 sd_fault = 1'b0;
  logic [15:0]          sd_fault_code = 16'h0000;
  logic [23:0]          preheat_cyc = 24'(PH);
  logic [23:0]          start_dly_cyc = 24'(SD);
  logic [23:0]          stop_dly_cyc = 24'h000006;
  logic                 wake_in_auto = 1'b0;
  gsm_pkg::gsm_screen_s screen_edit = '0;
  logic                 screen_save = 1'b0;
  logic                 screen_leave = 1'b0;
  gsm_pkg::gsm_mode_e   mode;
  logic                 run_cmd, load_on, shutdown_lamp, warning_lamp, status_lamp, sleep_state;
  logic                 sys_wake_out, sys_wake_oe;
  logic [15:0]          active_code;
  gsm_pkg::gsm_screen_s screen_applied;
  gsm_pkg::gsm_hist_s [gsm_pkg::HIST_DEPTH-1:0] history;
  wire logic            cfg_in3 = wk[1];
  wire logic            cfg_in4 = wk[2];
  // shared wake line: design level while it drives, else ours
  wire logic            sys_wake_in = sys_wake_oe ? sys_wake_out : wk[0];
  int                   n_mismatch = 0;
  int                   n_compared = 0;
  int                   n_cycles = 0;
  int                   n;

  always #12.5 clk = ~clk;

  gsm_panel pnl (.clk, .key_auto, .key_manual, .key_off, .key_any, .harness_fitted, .harness_manual,
    .harness_auto, .remote_start, .estop_local_open, .estop_remote_open);

  gsm_ctrl #(.SLEEP_CYC(SLP), .FLASH_CYC(4)) uut (.clk, .srst, .ce, .key_auto, .key_manual, .key_off, .key_any,
    .harness_fitted, .harness_manual, .harness_auto, .remote_start, .estop_local_open, .estop_remote_open,
    .cfg_in3, .cfg_in4, .sys_wake_in, .service_connector_jumper, .warn_fault, .sd_fault, .sd_fault_code,
    .preheat_cyc, .start_dly_cyc, .stop_dly_cyc, .wake_in_auto, .screen_edit, .screen_save, .screen_leave,
    .mode, .run_cmd, .load_on, .shutdown_lamp, .warning_lamp, .status_lamp, .sleep_state, .sys_wake_out,
    .sys_wake_oe, .active_code, .screen_applied, .history);

  task automatic summarize;
    if (n_mismatch == 0 && n_compared > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : summarize

  task automatic chkv(input logic [15:0] got, input logic [15:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("CHECK FAILED t=%0t got=%0h exp=%0h", $time, got, exp);
    end
  endtask : chkv

  task automatic chk1(input logic got, input logic exp);
    chkv(16'(got), 16'(exp));
  endtask : chk1

  // cycles then settle past the edge
  task automatic cyc(input int c);
    repeat (c) @(posedge clk);
    #1;
  endtask : cyc

  function automatic logic pick(input int s);
    return (s == 0) ? load_on : (s == 1) ? run_cmd : sleep_state;
  endfunction : pick

  task automatic wt(input int s, input logic v, output int c);
    for (c = 0; c < 90 && pick(s) !== v; c++)
      cyc(1);
  endtask : wt

  always @(posedge clk)
  begin
    n_cycles++;
    if (n_cycles == 4000)
    begin
      n_mismatch++;
      summarize();
    end
  end

  initial
  begin
    cyc(11);
    @(posedge clk) srst <= 1'b0;
    pnl.pins(6'h04);
    cyc(8);
    chk1(run_cmd, 1'b0);
    pnl.press(3'h1);
    cyc(3);
    chkv(16'(mode), 16'(gsm_pkg::GSM_MODE_AUTO));
    chk1(load_on, 1'b0);
    wt(0, 1'b1, n);
    chk1(n + 3 >= PH + SD, 1'b1);
    cyc(3);
    chk1(status_lamp, 1'b1);
    pnl.pins(6'h00);
    cyc(5);
    chk1(load_on, 1'b0);
    chk1(run_cmd, 1'b1);
    wt(1, 1'b0, n);
    chk1(run_cmd, 1'b0);
    @(posedge clk) {preheat_cyc, start_dly_cyc, stop_dly_cyc} <= 72'h0000FF;
    pnl.pins(6'h04);
    wt(0, 1'b1, n);
    chk1(n < 8, 1'b1);
    pnl.press(3'h4);
    cyc(1);
    chk1(run_cmd, 1'b0);
    chkv(16'(mode), 16'(gsm_pkg::GSM_MODE_OFF));
    pnl.press(3'h2);
    wt(0, 1'b1, n);
    chk1(load_on, 1'b1);
    pnl.pins(6'h00);
    cyc(8);
    pnl.pins(6'h04);
    cyc(8);
    chk1(run_cmd, 1'b1);
    pnl.pins(6'h00);
    @(posedge clk) warn_fault <= 1'b1;
    cyc(3);
    chk1(warning_lamp, 1'b1);
    chk1(load_on, 1'b1);
    @(posedge clk) warn_fault <= 1'b0;
    @(posedge clk) {sd_fault, sd_fault_code} <= {1'b1, 16'h00AB};
    cyc(2);
    chk1(load_on, 1'b0);
    wt(1, 1'b0, n);
    chk1(n < 4, 1'b1);
    chkv(history[0].code, 16'h00AB);
    chk1(history[0].active, 1'b1);
    @(posedge clk) sd_fault <= 1'b0;
    pnl.press(3'h4);
    cyc(2);
    chk1(shutdown_lamp, 1'b0);
    chk1(history[0].active, 1'b0);
    for (int k = 1; k <= 6; k++)
    begin
      @(posedge clk) {sd_fault, sd_fault_code} <= {1'b1, 16'(k)};
      cyc(2);
      @(posedge clk) sd_fault <= 1'b0;
      pnl.press(3'h4);
    end
    cyc(2);
    chkv(history[0].code, 16'h0006);
    chkv(history[4].code, 16'h0002);
    pnl.press(3'h2);
    wt(0, 1'b1, n);
    pnl.pins(6'h02);
    cyc(4);
    chk1(run_cmd, 1'b0);
    chk1(shutdown_lamp, 1'b1);
    chkv(active_code, gsm_pkg::CODE_ESTOP_LOCAL);
    pnl.pins(6'h03);
    cyc(4);
    chkv(active_code, gsm_pkg::CODE_ESTOP_REMOTE);
    pnl.press(3'h4);
    cyc(2);
    chk1(shutdown_lamp, 1'b1);
    pnl.pins(6'h00);
    cyc(4);
    chk1(shutdown_lamp, 1'b1);
    pnl.press(3'h4);
    cyc(2);
    chk1(shutdown_lamp, 1'b0);
    @(posedge clk) screen_edit <= {4'h3, 4'hC, 1'b0};
    @(posedge clk) screen_leave <= 1'b1;
    @(posedge clk) screen_leave <= 1'b0;
    cyc(3);
    chkv(16'(screen_applied), 16'({gsm_pkg::CONTRAST_RST, gsm_pkg::BRIGHTNESS_RST, gsm_pkg::IMPERIAL_RST}));
    @(posedge clk) screen_save <= 1'b1;
    @(posedge clk) screen_save <= 1'b0;
    cyc(2);
    chkv(16'(screen_applied), 16'h0078);
    @(posedge clk) service_connector_jumper <= 1'b1;
    cyc(SLP + 20);
    chk1(sleep_state, 1'b0);
    @(posedge clk) service_connector_jumper <= 1'b0;
    wt(2, 1'b1, n);
    chk1(sleep_state, 1'b1);
    pnl.press(3'h0);
    cyc(2);
    chk1(sleep_state, 1'b0);
    // frozen cycles must not count towards sleep
    @(posedge clk) ce <= 1'b0;
    cyc(30);
    @(posedge clk) ce <= 1'b1;
    cyc(SLP - 10);
    chk1(sleep_state, 1'b0);
    for (int i = 0; i < 3; i++)
    begin
      wt(2, 1'b1, n);
      chk1(sleep_state, 1'b1);
      @(posedge clk) wk[i] <= 1'b1;
      cyc(4);
      chk1(sleep_state, 1'b0);
      @(posedge clk) wk <= 3'h0;
    end
    wt(2, 1'b1, n);
    pnl.pins(6'h30);
    cyc(4);
    chk1(sleep_state, 1'b0);
    pnl.pins(6'h20);
    wt(1, 1'b0, n);
    chk1(run_cmd, 1'b0);
    wt(2, 1'b1, n);
    pnl.pins(6'h28);
    cyc(6);
    chk1(sleep_state, 1'b1);
    pnl.pins(6'h20);
    cyc(4);
    @(posedge clk) wake_in_auto <= 1'b1;
    pnl.pins(6'h28);
    cyc(4);
    chk1(sleep_state, 1'b0);
    summarize();
  end
endmodule : tb
